// ---- include/deadtime_ref_pkg.sv ----
package deadtime_ref_pkg;
    // Register byte offsets on the Avalon-MM bus
    localparam logic [3:0] DEAD_TIME_OFFS = 4'h0;
    localparam logic [3:0] SETPOINT_OFFS  = 4'h4;
    localparam logic [3:0] AUX_SET_OFFS   = 4'h8;
    localparam logic [3:0] DRV_CTRL_OFFS  = 4'hC;
    // Low address bits at which the read-only calibration word is mirrored
    localparam logic [1:0] CAL_MIRROR_SEL = 2'h1;
    // Avalon-MM response codes
    localparam logic [1:0] RESP_OKAY      = 2'h0;
    localparam logic [1:0] RESP_SLVERR    = 2'h2;
    // Reset values
    localparam logic [7:0] DEAD_TIME_RST  = 8'h00;
    localparam logic [7:0] SETPOINT_RST   = 8'h00;
    localparam logic [7:0] AUX_SET_RST    = 8'h00;
    localparam logic [7:0] DRV_CTRL_RST   = 8'h00;
    // Field positions
    localparam int PRI_CODE_LSB   = 4;
    localparam int SEC_CODE_LSB   = 0;
    localparam int PRI_BYPASS_BIT = 1;
    localparam int SEC_BYPASS_BIT = 0;
    localparam int MODE_SEL_LSB   = 2;
    // Master/slave field value that routes the aux reference to its pin
    localparam logic [1:0] MODE_MASTER = 2'h1;
    // Dead-time step and clock
    localparam int STEP_NS      = 16;
    localparam int CLK_PERIOD_NS = 5;
    localparam int STEP_CYCLES  = (STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // Calibration word location
    localparam logic [15:0] CAL_WORD_ADDR = 16'h208B;
endpackage : deadtime_ref_pkg

// ---- logic/turn_on_delay.sv ----
// Delays the rising edge of one gate-drive signal; falling edges pass at once
module turn_on_delay
    import deadtime_ref_pkg::*;
#(
    parameter int CNT_W = 8
) (
    input  wire logic             clk,        // System clock
    input  wire logic             rst_n,      // Async reset, active low
    input  wire logic             drive_in,   // Raw gate request
    input  wire logic [3:0]       code,       // Dead-time code
    input  wire logic             bypass,     // Skip delay
    output logic                  drive_out   // Delayed gate drive
);
    logic [CNT_W-1:0] cnt_q;
    logic [CNT_W-1:0] target;

    // Cycles for (code+1) steps, each 16 ns rounded up to whole cycles
    assign target = CNT_W'((32'(code) + 1) * STEP_CYCLES);

    // Count while request is high, release after target
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_q <= '0;
        end else if (!drive_in) begin
            cnt_q <= '0; // Turn-off resets the timer
        end else if (cnt_q < target) begin
            cnt_q <= cnt_q + 1'b1;
        end
    end

    // Output register
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            drive_out <= 1'b0;
        end else if (bypass) begin
            drive_out <= drive_in; // No dead time when bypassed
        end else begin
            drive_out <= drive_in && (cnt_q + 1'b1 >= target); // Rising delayed, falling immediate
        end
    end
endmodule : turn_on_delay

// ---- logic/deadtime_ref_config.sv ----
// Functional notes
// - Secondary code n gives 20ns*(n+1) delay (16 ns step rounded up to 4 cycles of 5 ns)
// - Primary upper nibble, same mapping, independent
// - Per-driver bypass skips dead time
// - Main set-point code drives 8-bit DAC
// - Main DAC 255 steps, monotonic code
// - Aux reference on pin only in master
// - Aux DAC ground referenced, no pedestal
// - Aux set-point code drives linear DAC
// - Gain calibration word readable by firmware
module deadtime_ref_config
    import deadtime_ref_pkg::*;
#(
    parameter logic [7:0] CAL_WORD = 8'h80    // Factory gain word, arbitrary default
) (
    input  wire logic        clk,                  // System clock
    input  wire logic        rst_n,                // Async reset, active low
    input  wire logic [3:0]  avs_address,          // Byte address
    input  wire logic        avs_read,             // Read strobe
    input  wire logic        avs_write,            // Write strobe
    input  wire logic [31:0] avs_writedata,        // Write data
    input  wire logic [3:0]  avs_byteenable,       // Byte enables
    output logic      [31:0] avs_readdata,         // Read data
    output logic             avs_waitrequest,      // Stall
    output logic      [1:0]  avs_response,         // 00 ok, 10 slave error
    input  wire logic        primary_pwm,          // Raw primary request
    input  wire logic        secondary_pwm,        // Raw secondary request
    output logic             primary_gate_drive,   // Delayed primary drive
    output logic             secondary_gate_drive, // Delayed secondary drive
    output logic      [7:0]  regulation_dac_code,  // Main DAC code
    output logic      [7:0]  aux_dac_code,         // Aux DAC code
    output logic             aux_reference_pin_en, // Aux DAC onto pin
    output logic      [7:0]  amp_gain_cal_word     // Calibration word
);
    // Register contents
    logic [7:0] driver_dead_time_select_q;     // Primary and secondary dead-time codes
    logic [7:0] regulation_setpoint_code_q;    // Main reference code
    logic [7:0] aux_reference_setpoint_code_q; // Auxiliary reference code
    logic [7:0] drive_control_q;               // Bypass bits and mode select
    // Bus handshake
    logic       waitrequest_q;                 // Stall, high while idle
    logic       request;                       // Read or write held by the master
    logic       capture;                       // First edge of a transfer
    logic       accept;                        // Answering edge of a transfer
    // Address decode
    logic       hit;                           // Address is mapped
    logic [7:0] rd_mux;                        // Byte offered to a read
    // Field views
    logic [3:0] primary_deadtime_code;         // Upper nibble of the dead-time register
    logic [3:0] secondary_deadtime_code;       // Lower nibble of the dead-time register
    logic       primary_deadtime_bypass;       // Skip primary turn-on delay
    logic       secondary_deadtime_bypass;     // Skip secondary turn-on delay
    logic [1:0] master_slave_select;           // Mode field, master routes aux reference
    // Write strobes
    logic       wr_dead;                       // Dead-time register write
    logic       wr_setp;                       // Main set-point write
    logic       wr_aux;                        // Aux set-point write
    logic       wr_ctrl;                       // Control register write

    // Named fields of the dead-time and control registers
    assign primary_deadtime_code     = driver_dead_time_select_q[PRI_CODE_LSB +: 4];
    assign secondary_deadtime_code   = driver_dead_time_select_q[SEC_CODE_LSB +: 4];
    assign primary_deadtime_bypass   = drive_control_q[PRI_BYPASS_BIT];
    assign secondary_deadtime_bypass = drive_control_q[SEC_BYPASS_BIT];
    assign master_slave_select       = drive_control_q[MODE_SEL_LSB +: 2];

    // Transfer pending, its first edge and its answering edge
    assign request = avs_read || avs_write;
    assign capture = request && waitrequest_q;
    assign accept  = request && !waitrequest_q;

    // Stall flop: idle high, low for the single cycle in which a transfer completes
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            waitrequest_q <= 1'b1;
        end else if (capture) begin
            waitrequest_q <= 1'b0;
        end else begin
            waitrequest_q <= 1'b1;
        end
    end

    // Stall output taken straight from its flop, so the master never sees a glitch
    assign avs_waitrequest = waitrequest_q;

    // Address decode and read mux; the calibration word is mirrored read-only
    always_comb begin
        hit    = 1'b1;
        rd_mux = 8'h00;
        case (avs_address)
            DEAD_TIME_OFFS: rd_mux = driver_dead_time_select_q;
            SETPOINT_OFFS:  rd_mux = regulation_setpoint_code_q;
            AUX_SET_OFFS:   rd_mux = aux_reference_setpoint_code_q;
            DRV_CTRL_OFFS:  rd_mux = drive_control_q;
            default: begin
                if (avs_address[1:0] == CAL_MIRROR_SEL) begin
                    rd_mux = CAL_WORD; // Read-only calibration word, valid from reset
                end else begin
                    hit = 1'b0;
                end
            end
        endcase
    end

    // Read data, loaded on the first edge and standing until the next transfer
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            avs_readdata <= 32'h0000_0000;
        end else if (capture) begin
            avs_readdata <= {24'h00_0000, rd_mux};
        end
    end

    // Response code, loaded together with the read data
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            avs_response <= RESP_OKAY;
        end else if (capture) begin
            avs_response <= hit ? RESP_OKAY : RESP_SLVERR;
        end
    end

    // One write strobe per register, byte lane 0 only, on the answering edge
    always_comb begin
        wr_dead = 1'b0;
        wr_setp = 1'b0;
        wr_aux  = 1'b0;
        wr_ctrl = 1'b0;
        if (avs_write && accept && avs_byteenable[0]) begin
            case (avs_address)
                DEAD_TIME_OFFS: wr_dead = 1'b1;
                SETPOINT_OFFS:  wr_setp = 1'b1;
                AUX_SET_OFFS:   wr_aux  = 1'b1;
                DRV_CTRL_OFFS:  wr_ctrl = 1'b1;
                default:        ; // Calibration mirror and holes ignore writes
            endcase
        end
    end

    // Dead-time register: primary code upper nibble, secondary lower nibble
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            driver_dead_time_select_q <= DEAD_TIME_RST;
        end else if (wr_dead) begin
            driver_dead_time_select_q <= avs_writedata[7:0];
        end
    end

    // Main set-point register, holds the gain-corrected code from firmware
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            regulation_setpoint_code_q <= SETPOINT_RST;
        end else if (wr_setp) begin
            regulation_setpoint_code_q <= avs_writedata[7:0];
        end
    end

    // Aux set-point register, stepped by firmware while trimming
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            aux_reference_setpoint_code_q <= AUX_SET_RST;
        end else if (wr_aux) begin
            aux_reference_setpoint_code_q <= avs_writedata[7:0];
        end
    end

    // Control register; upper nibble reads as zero
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            drive_control_q <= DRV_CTRL_RST;
        end else if (wr_ctrl) begin
            drive_control_q <= {4'h0, avs_writedata[3:0]};
        end
    end

    // Main reference DAC code: linear, Vbg*code/255 in monotonic steps
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            regulation_dac_code <= SETPOINT_RST;
        end else begin
            regulation_dac_code <= regulation_setpoint_code_q;
        end
    end

    // Aux reference DAC code: ground referenced, no pedestal added
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            aux_dac_code <= AUX_SET_RST;
        end else begin
            aux_dac_code <= aux_reference_setpoint_code_q;
        end
    end

    // Aux reference reaches its pin only in master mode
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            aux_reference_pin_en <= 1'b0;
        end else begin
            aux_reference_pin_en <= (master_slave_select == MODE_MASTER);
        end
    end

    // Calibration word presented to firmware
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            amp_gain_cal_word <= '0;
        end else begin
            amp_gain_cal_word <= CAL_WORD;
        end
    end

    // Primary driver dead time
    turn_on_delay u_pri (
        .clk       (clk),
        .rst_n     (rst_n),
        .drive_in  (primary_pwm),
        .code      (primary_deadtime_code),
        .bypass    (primary_deadtime_bypass),
        .drive_out (primary_gate_drive)
    );

    // Secondary driver dead time
    turn_on_delay u_sec (
        .clk       (clk),
        .rst_n     (rst_n),
        .drive_in  (secondary_pwm),
        .code      (secondary_deadtime_code),
        .bypass    (secondary_deadtime_bypass),
        .drive_out (secondary_gate_drive)
    );
endmodule : deadtime_ref_config

// ---- bench/deadtime_ref_config_chk.sv ----
module deadtime_ref_config_chk
    import deadtime_ref_pkg::*;
#(
    parameter logic [7:0] CAL_WORD = 8'h80        // Expected calibration word
) (
    input wire logic        clk,                  // System clock
    input wire logic        rst_n,                // Async reset, active low
    input wire logic        avs_read,             // Read strobe
    input wire logic        avs_write,            // Write strobe
    input wire logic        avs_waitrequest,      // Stall
    input wire logic [3:0]  avs_address,          // Byte address
    input wire logic [3:0]  avs_byteenable,       // Byte enables
    input wire logic [31:0] avs_writedata,        // Write data
    input wire logic [31:0] avs_readdata,         // Read data
    input wire logic [1:0]  avs_response,         // Response code
    input wire logic        primary_pwm,          // Raw primary request
    input wire logic        secondary_pwm,        // Raw secondary request
    input wire logic        primary_gate_drive,   // Delayed primary drive
    input wire logic        secondary_gate_drive, // Delayed secondary drive
    input wire logic [7:0]  regulation_dac_code,  // Main DAC code
    input wire logic [7:0]  aux_dac_code,         // Aux DAC code
    input wire logic        aux_reference_pin_en, // Aux DAC onto pin
    input wire logic [7:0]  amp_gain_cal_word     // Calibration word
);
    timeunit 1ns;
    timeprecision 100ps;
    logic wr_ok;
    // Write accepted on byte lane 0
    assign wr_ok = avs_write && !avs_waitrequest && avs_byteenable[0];
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    a_one_wait: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest) else $error("stall");
    a_unmapped_err: assert property (avs_read && !avs_waitrequest && avs_address[1] |-> avs_response == 2'h2)
        else $error("no error");
    a_main_dac: assert property (wr_ok && avs_address == SETPOINT_OFFS |-> ##2
        regulation_dac_code == $past(avs_writedata[7:0], 2)) else $error("main code");
    a_aux_dac: assert property (wr_ok && avs_address == AUX_SET_OFFS |-> ##2
        aux_dac_code == $past(avs_writedata[7:0], 2)) else $error("aux code");
    a_master_pin: assert property (wr_ok && avs_address == DRV_CTRL_OFFS |-> ##2
        aux_reference_pin_en == ($past(avs_writedata[3:2], 2) == MODE_MASTER)) else $error("pin enable");
    a_cal_word: assert property ($past(rst_n) |-> amp_gain_cal_word == CAL_WORD) else $error("cal word");
    a_pri_fall: assert property ($fell(primary_pwm) |=> !primary_gate_drive) else $error("slow fall");
    a_sec_rise: assert property ($rose(secondary_gate_drive) |-> $past(secondary_pwm)) else $error("early");
endmodule : deadtime_ref_config_chk
bind deadtime_ref_config deadtime_ref_config_chk #(.CAL_WORD(CAL_WORD)) chk_inst (.*);

// ---- bench/pwm_source.sv ----
module pwm_source (
    input  wire logic clk,          // System clock
    input  wire logic rst_n,        // Reset, active low
    output logic      primary_pwm,  // Primary request
    output logic      secondary_pwm // Secondary request
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [7:0] phase_q;
    // 160-cycle period, requests in alternate halves
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) phase_q <= 8'h00;
        else phase_q <= (phase_q == 8'h9F) ? 8'h00 : phase_q + 8'h01;
    end
    assign primary_pwm = rst_n && phase_q < 8'h50;
    assign secondary_pwm = rst_n && phase_q >= 8'h50;
endmodule : pwm_source

// ---- bench/deadtime_ref_config_bench.sv ----
module deadtime_ref_config_bench import deadtime_ref_pkg::*;;
    timeunit 1ns;
    timeprecision 100ps;
    localparam logic [7:0] CAL_WORD = 8'h9A; // Arbitrary gain word
    logic clk = 1'b0, rst_n = 1'b0, avs_read = 1'b0, avs_write = 1'b0, avs_waitrequest, aux_reference_pin_en;
    logic primary_pwm, secondary_pwm, primary_gate_drive, secondary_gate_drive;
    logic [3:0] avs_address = 4'h0, avs_byteenable = 4'hF;
    logic [31:0] avs_writedata = 32'h0, avs_readdata, rd;
    logic [1:0] avs_response, rsp;
    logic [7:0] regulation_dac_code, aux_dac_code, amp_gain_cal_word;
    int mismatches = 0, compares = 0, n;
    // Dead time, control, primary cycles, secondary cycles, pin enable
    logic [7:0] rows [5][5] = '{'{8'h0F, 8'h00, 8'h04, 8'h40, 8'h00}, '{8'hF0, 8'h04, 8'h40, 8'h04, 8'h01},
        '{8'h37, 8'h0B, 8'h01, 8'h01, 8'h00}, '{8'h5A, 8'h0D, 8'h18, 8'h01, 8'h00}, '{8'h3C, 8'h06, 8'h01, 8'h34, 8'h01}};
    deadtime_ref_config #(.CAL_WORD(CAL_WORD)) DUT (.*);
    pwm_source pwm (.clk(clk), .rst_n(rst_n), .primary_pwm(primary_pwm), .secondary_pwm(secondary_pwm));
    always #2.5 clk = ~clk;
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            mismatches++;
            $display("unexpected at %0t: got %h want %h", $time, seen, exp);
        end
    endtask : chk
    // One bus transfer, entered just after a rising edge
    task automatic bus(input logic wr, input logic [3:0] a, input logic [7:0] d);
        avs_address <= a;
        avs_write <= wr;
        avs_read <= !wr;
        avs_writedata <= {24'h0, d};
        do @(posedge clk); while (avs_waitrequest !== 1'b0);
        rd = avs_readdata;
        rsp = avs_response;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
        @(posedge clk);
    endtask : bus
    // Cycles from a request rising to its drive rising
    task automatic meas(input logic sec, output int cyc);
        cyc = 0;
        @(negedge clk iff (sec ? secondary_pwm : primary_pwm) === 1'b0);
        @(negedge clk iff (sec ? secondary_pwm : primary_pwm) === 1'b1);
        while ((sec ? secondary_gate_drive : primary_gate_drive) !== 1'b1 && cyc < 99) begin
            @(negedge clk);
            cyc++;
        end
        @(posedge clk);
    endtask : meas
    task end_of_test;
        $display("mismatches %0d compares %0d", mismatches, compares);
        if (mismatches == 0 && compares > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : end_of_test
    // Table loop, then register and reset cases
    initial begin
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        foreach (rows[i]) begin
            bus(1'b1, DEAD_TIME_OFFS, rows[i][0]);
            bus(1'b1, DRV_CTRL_OFFS, rows[i][1]);
            meas(1'b0, n);
            chk(32'(n), rows[i][2]);
            meas(1'b1, n);
            chk(32'(n), rows[i][3]);
            chk(aux_reference_pin_en, rows[i][4]);
        end
        bus(1'b1, SETPOINT_OFFS, 8'((16'(8'hC8) * CAL_WORD) >> 7));
        bus(1'b0, SETPOINT_OFFS, 8'h00);
        chk(rd, 32'hF0);
        chk(regulation_dac_code, 8'hF0);
        avs_byteenable <= 4'hE;
        bus(1'b1, SETPOINT_OFFS, 8'h11);
        avs_byteenable <= 4'hF;
        bus(1'b0, SETPOINT_OFFS, 8'h00);
        chk(rd, 32'hF0);
        bus(1'b1, AUX_SET_OFFS, 8'hFF);
        @(negedge clk);
        chk(aux_dac_code, 8'hFF);
        @(posedge clk);
        bus(1'b1, 4'h5, 8'h00);
        bus(1'b0, 4'h5, 8'h00);
        chk(rd, CAL_WORD);
        chk(amp_gain_cal_word, CAL_WORD);
        bus(1'b0, 4'h2, 8'h00);
        chk(rsp, 2'h2);
        rst_n <= 1'b0;
        @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        bus(1'b0, AUX_SET_OFFS, 8'h00);
        chk(rd, 32'h0);
        chk(aux_reference_pin_en, 1'b0);
        end_of_test();
    end
    // Watchdog against a hung handshake
    initial begin
        repeat (20000) @(posedge clk);
        mismatches++;
        end_of_test();
    end
endmodule : deadtime_ref_config_bench
